//--- design/isc_top.sv
// Interrupt source controller with vectored nesting
//
// Design decisions made here: the register addresses and the Wishbone slave port.
`timescale 1ns/1ps
`default_nettype none
module isc_top
  import isc_pkg::*;
(
  input  wire logic              clk,
  input  wire logic              rst,
  input  wire logic [SrcHi:2]    periphReq,
  input  wire logic              wakeReq,
  input  wire logic              wdogReq,
  input  wire logic              wbCyc,
  input  wire logic              wbStb,
  input  wire logic              wbWe,
  input  wire logic [AdrW-1:0]   wbAdr,
  input  wire logic [3:0]        wbSel,
  input  wire logic [31:0]       wbDatI,
  output logic      [31:0]       wbDatO,
  output logic                   wbAck,
  output logic                   irqReq,
  output logic                   fiqReq,
  output logic                   intOut
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);

  //----------------------------------------------------------
  // Bus front end
  //----------------------------------------------------------
  logic             wrStb;
  logic             rdStb;
  logic [31:0]      wMask;
  logic [31:0]      wBits;
  logic [31:0]      rdData;

  isc_wb_slave u_bus (
    .clk    (clk),
    .rst    (rst),
    .wbCyc  (wbCyc),
    .wbStb  (wbStb),
    .wbWe   (wbWe),
    .wbSel  (wbSel),
    .rdData (rdData),
    .wbDatO (wbDatO),
    .wbAck  (wbAck),
    .wrStb  (wrStb),
    .rdStb  (rdStb),
    .wMask  (wMask)
  );

  assign wBits = wbDatI & wMask;

  //----------------------------------------------------------
  // Source sampling
  //----------------------------------------------------------
  logic [SrcHi:1]   raw_q;
  logic             swi_q;
  logic [SrcHi:2]   raw_d;

  always_comb
  begin
    raw_d = periphReq;
    raw_d[BitTmr2] = periphReq[BitTmr2] | wakeReq;
    raw_d[BitTmr3] = periphReq[BitTmr3] | wdogReq;
  end

  // Bits 6,7 flash blocks; 8 ADC; 9,10 UARTs
  always_ff @(posedge clk)
  begin
    if (rst) raw_q <= '0;
    else raw_q <= {raw_d, swi_q};
  end

  always_ff @(posedge clk)
  begin
    if (rst) swi_q <= 1'b0;
    else if (wrStb && wbAdr == OffSwi && wbSel[0])
      swi_q <= wbDatI[0];
  end

  //----------------------------------------------------------
  // Enable masks
  //----------------------------------------------------------
  logic [SrcHi:1]   irq_enable_mask_q;
  logic [SrcHi:1]   fiqEn_q;
  logic [SrcHi:1]   irq_active_status;
  logic [SrcHi:1]   fiqAct;
  logic [SrcHi:0]   fiq_active_status;

  always_ff @(posedge clk)
  begin
    if (rst) irq_enable_mask_q <= '0;
    else if (wrStb && wbAdr == OffIrqEn)
      irq_enable_mask_q <= irq_enable_mask_q | wBits[SrcHi:1];
    else if (wrStb && wbAdr == OffIrqClr)
      irq_enable_mask_q <= irq_enable_mask_q & ~wBits[SrcHi:1];
  end

  always_ff @(posedge clk)
  begin
    if (rst) fiqEn_q <= '0;
    else if (wrStb && wbAdr == OffFiqEn)
      fiqEn_q <= fiqEn_q | wBits[SrcHi:1];
    else if (wrStb && wbAdr == OffFiqClr)
      fiqEn_q <= fiqEn_q & ~wBits[SrcHi:1];
  end

  assign irq_active_status = raw_q & irq_enable_mask_q;
  assign fiqAct = raw_q & fiqEn_q;
  assign fiq_active_status = {fiqAct, |fiqAct};

  //----------------------------------------------------------
  // Priorities and nesting
  //----------------------------------------------------------
  logic [LvlW-1:0]  prio_q [1:SrcHi];
  logic [127:0]     prioFlat;
  logic             nestEn_q;
  logic [NumLvl-1:0] inSvc_q;
  logic [LvlW-1:0]  curLvl;
  logic             svcAny;

  isc_prio_if pif ();

  isc_prio_enc u_enc (
    .pif (pif.enc)
  );

  assign pif.active = irq_active_status;
  assign prioFlat[3:0] = 4'h0;
  assign prioFlat[127:104] = 24'h00_0000;

  for (genvar s = 1; s <= SrcHi; s++)
  begin : g_prio
    localparam logic [AdrW-1:0] Off = OffPrio0 + AdrW'(4 * (s / 8));
    localparam int Nib = (s % 8) * 4;
    always_ff @(posedge clk)
    begin
      if (rst) prio_q[s] <= '0;
      else if (wrStb && wbAdr == Off && wbSel[Nib / 8])
        prio_q[s] <= wbDatI[Nib +: LvlW];
    end
    assign pif.prio[s] = prio_q[s];
    assign prioFlat[s*4 +: 4] = {1'b0, prio_q[s]};
  end

  always_ff @(posedge clk)
  begin
    if (rst) nestEn_q <= 1'b0;
    else if (wrStb && wbAdr == OffNest && wbSel[0])
      nestEn_q <= wbDatI[0];
  end

  always_comb
  begin
    svcAny = |inSvc_q;
    curLvl = LvlW'(NumLvl - 1);
    for (int i = NumLvl - 1; i >= 0; i--)
    begin
      if (inSvc_q[i]) curLvl = LvlW'(i);
    end
  end

  // Vector read enters a level; end-of-service write leaves the top one
  always_ff @(posedge clk)
  begin
    if (rst) inSvc_q <= '0;
    else if (!nestEn_q) inSvc_q <= '0;
    else if (rdStb && wbAdr == OffVec && pif.bestValid)
      inSvc_q[pif.bestLvl] <= 1'b1;
    else if (wrStb && wbAdr == OffEoi && svcAny)
      inSvc_q[curLvl] <= 1'b0;
  end

  //----------------------------------------------------------
  // Core request lines
  //----------------------------------------------------------
  always_ff @(posedge clk)
  begin
    if (rst) irqReq <= 1'b0;
    else if (nestEn_q)
      irqReq <= pif.bestValid && (!svcAny || pif.bestLvl < curLvl);
    else irqReq <= |irq_active_status;
  end

  always_ff @(posedge clk)
  begin
    if (rst) fiqReq <= 1'b0;
    else fiqReq <= fiq_active_status[BitFiqAll];
  end

  //----------------------------------------------------------
  // Controller events
  //----------------------------------------------------------
  logic             irqPrev_q;
  logic             fiqPrev_q;
  logic [1:0]       evtSet;
  logic [1:0]       evtSta_q;
  logic [1:0]       evtMsk_q;

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      irqPrev_q <= 1'b0;
      fiqPrev_q <= 1'b0;
    end
    else
    begin
      irqPrev_q <= irqReq;
      fiqPrev_q <= fiqReq;
    end
  end

  assign evtSet[EvtIrq] = irqReq & ~irqPrev_q;
  assign evtSet[EvtFiq] = fiqReq & ~fiqPrev_q;

  // Set wins over a same-cycle clear
  always_ff @(posedge clk)
  begin
    if (rst) evtSta_q <= 2'h0;
    else if (wrStb && wbAdr == OffEvtSta)
      evtSta_q <= (evtSta_q & ~wBits[1:0]) | evtSet;
    else evtSta_q <= evtSta_q | evtSet;
  end

  always_ff @(posedge clk)
  begin
    if (rst) evtMsk_q <= 2'h0;
    else if (wrStb && wbAdr == OffEvtMsk)
      evtMsk_q <= (evtMsk_q & ~wMask[1:0]) | wBits[1:0];
  end

  always_ff @(posedge clk)
  begin
    if (rst) intOut <= 1'b0;
    else intOut <= |(evtSta_q & evtMsk_q);
  end

  //----------------------------------------------------------
  // Read multiplexer
  //----------------------------------------------------------
  always_comb
  begin
    rdData = RdZero;
    unique case (wbAdr)
      OffIrqSta: rdData = 32'({irq_active_status, 1'b0});
      OffIrqRaw: rdData = 32'({raw_q, 1'b0});
      OffIrqEn: rdData = 32'({irq_enable_mask_q, 1'b0});
      OffSwi: rdData = 32'(swi_q);
      OffNest: rdData = 32'(nestEn_q);
      OffVec: rdData = 32'({pif.bestValid, 4'h0, svcAny, curLvl,
                            pif.bestLvl, pif.bestSrc});
      OffEoi: rdData = 32'(inSvc_q);
      OffPrio0: rdData = prioFlat[31:0];
      OffPrio0 + 12'h004: rdData = prioFlat[63:32];
      OffPrio0 + 12'h008: rdData = prioFlat[95:64];
      OffPrio0 + 12'h00C: rdData = prioFlat[127:96];
      OffEvtSta: rdData = 32'(evtSta_q);
      OffEvtMsk: rdData = 32'(evtMsk_q);
      OffFiqSta: rdData = 32'(fiq_active_status);
      OffFiqRaw: rdData = 32'({raw_q, 1'b0});
      OffFiqEn: rdData = 32'({fiqEn_q, 1'b0});
      default: rdData = RdZero;
    endcase
  end

  //----------------------------------------------------------
  // Checks
  //----------------------------------------------------------
  sequence s_clr_write;
    wrStb && wbAdr == OffIrqClr;
  endsequence

  property p_clr_effect;
    logic [SrcHi:1] bits;
    (s_clr_write, bits = wBits[SrcHi:1]) |=> (irq_enable_mask_q & bits) == '0;
  endproperty

  a_clr_masks_bits: assert property (p_clr_effect)
    else $error("clear write left a mask bit set");

  a_clr_keeps_rest: assert property (s_clr_write |=>
    (irq_enable_mask_q & ~$past(wBits[SrcHi:1]))
      == ($past(irq_enable_mask_q) & ~$past(wBits[SrcHi:1])))
    else $error("clear write disturbed other mask bits");

  a_irq_or_line: assert property (!nestEn_q && |irq_active_status |=> irqReq)
    else $error("active source did not raise irq");

  a_irq_quiet_line: assert property (!nestEn_q && ~|irq_active_status |=> !irqReq)
    else $error("irq raised without active source");

  a_fiq_aggregate: assert property (fiq_active_status[0] == |fiqAct ##1
    fiqReq == $past(|fiqAct))
    else $error("fiq aggregate bit or line wrong");

  a_raw_follows_req: assert property (##1 raw_q[SrcHi:6]
    == $past(periphReq[SrcHi:6]))
    else $error("raw source did not follow request");

  a_timer_share: assert property (wakeReq || wdogReq
    |=> (raw_q[BitTmr2] || !$past(wakeReq))
      && (raw_q[BitTmr3] || !$past(wdogReq)))
    else $error("shared timer event lost");

  a_swi_write: assert property (wrStb && wbAdr == OffSwi && wbSel[0]
    |=> ##1 raw_q[BitSwi] == $past(wbDatI[0], 2))
    else $error("software interrupt bit not written");

  a_sta_and_mask: assert property (rdStb && wbAdr == OffIrqSta
    |=> wbDatO[SrcHi:1] == $past(raw_q & irq_enable_mask_q))
    else $error("active status read is not raw AND mask");

  a_nest_blocks: assert property (nestEn_q && svcAny
    && pif.bestLvl >= curLvl |=> !irqReq)
    else $error("equal or lower level preempted service");

  a_nest_off_clear: assert property (!nestEn_q |=> inSvc_q == '0)
    else $error("nesting state kept while disabled");

  a_evt_set_wins: assert property (evtSet[EvtIrq] |=> evtSta_q[EvtIrq])
    else $error("irq event lost");

  sequence s_vec_enter;
    nestEn_q && rdStb && wbAdr == OffVec && pif.bestValid;
  endsequence

  sequence s_eoi_write;
    nestEn_q && wrStb && wbAdr == OffEoi && svcAny;
  endsequence

  a_vec_enters_lvl: assert property (s_vec_enter |=>
    inSvc_q[$past(pif.bestLvl)])
    else $error("vector read did not enter its level");

  a_eoi_leaves_lvl: assert property (s_eoi_write |=>
    !inSvc_q[$past(curLvl)])
    else $error("end of service kept the current level");

  a_mask_set_bits: assert property (wrStb && wbAdr == OffIrqEn |=>
    (irq_enable_mask_q & $past(wBits[SrcHi:1])) == $past(wBits[SrcHi:1]))
    else $error("enable write did not set its mask bits");

  a_mask_keeps_rest: assert property (wrStb && wbAdr == OffIrqEn |=>
    (irq_enable_mask_q | $past(wBits[SrcHi:1]))
      == ($past(irq_enable_mask_q) | $past(wBits[SrcHi:1])))
    else $error("enable write disturbed other mask bits");

  a_prio_nibble: assert property (wrStb && wbAdr == OffPrio0 + 12'h004
    && wbSel[0] |=> prio_q[8] == $past(wbDatI[LvlW-1:0]))
    else $error("priority write missed its nibble");

endmodule // isc_top
`default_nettype wire

//--- design/isc_pkg.sv
// Constants shared by the interrupt source controller
//------------------------------------------------------------
//------------------------------------------------------------
package isc_pkg;
  localparam int unsigned NumSrc = 25;
  localparam int unsigned SrcHi = 25;
  localparam int unsigned LvlW = 3;
  localparam int unsigned NumLvl = 8;
  localparam int unsigned AdrW = 12;
  localparam int unsigned BitFiqAll = 0;
  localparam int unsigned BitSwi = 1;
  localparam int unsigned BitTmr2 = 4;
  localparam int unsigned BitTmr3 = 5;
  localparam int unsigned EvtIrq = 0;
  localparam int unsigned EvtFiq = 1;
  localparam logic [AdrW-1:0] OffIrqSta = 12'h000;
  localparam logic [AdrW-1:0] OffIrqRaw = 12'h004;
  localparam logic [AdrW-1:0] OffIrqEn = 12'h008;
  localparam logic [AdrW-1:0] OffIrqClr = 12'h00C;
  localparam logic [AdrW-1:0] OffSwi = 12'h010;
  localparam logic [AdrW-1:0] OffNest = 12'h014;
  localparam logic [AdrW-1:0] OffVec = 12'h018;
  localparam logic [AdrW-1:0] OffEoi = 12'h01C;
  localparam logic [AdrW-1:0] OffPrio0 = 12'h020;
  localparam logic [AdrW-1:0] OffEvtSta = 12'h030;
  localparam logic [AdrW-1:0] OffEvtMsk = 12'h034;
  localparam logic [AdrW-1:0] OffFiqSta = 12'h100;
  localparam logic [AdrW-1:0] OffFiqRaw = 12'h104;
  localparam logic [AdrW-1:0] OffFiqEn = 12'h108;
  localparam logic [AdrW-1:0] OffFiqClr = 12'h10C;
  localparam logic [31:0] RdZero = 32'h0000_0000;
endpackage

//--- design/isc_prio_if.sv
// Carrier between the controller and its priority resolver
`timescale 1ns/1ps
`default_nettype none
interface isc_prio_if;
  import isc_pkg::*;
  logic [SrcHi:1]   active;
  logic [LvlW-1:0]  prio [1:SrcHi];
  logic             bestValid;
  logic [4:0]       bestSrc;
  logic [LvlW-1:0]  bestLvl;
  modport enc (input active, prio, output bestValid, bestSrc, bestLvl);
  modport ctl (output active, prio, input bestValid, bestSrc, bestLvl);
endinterface
`default_nettype wire

//--- design/isc_prio_enc.sv
// Priority resolver: picks the most urgent active source
`timescale 1ns/1ps
`default_nettype none
module isc_prio_enc
  import isc_pkg::*;
(
  isc_prio_if.enc pif
);
  //----------------------------------------------------------
  // Lowest level value wins, ties go to the lowest bit
  //----------------------------------------------------------
  always_comb
  begin
    pif.bestValid = 1'b0;
    pif.bestSrc = 5'h00;
    pif.bestLvl = '1;
    for (int s = SrcHi; s >= 1; s--)
    begin
      if (pif.active[s] && (!pif.bestValid || pif.prio[s] <= pif.bestLvl))
      begin
        pif.bestValid = 1'b1;
        pif.bestSrc = 5'(s);
        pif.bestLvl = pif.prio[s];
      end
    end
  end
endmodule // isc_prio_enc
`default_nettype wire

//--- design/isc_wb_slave.sv
// Classic Wishbone slave front end with registered answer
`timescale 1ns/1ps
`default_nettype none
module isc_wb_slave
  import isc_pkg::*;
(
  input  wire logic         clk,
  input  wire logic         rst,
  input  wire logic         wbCyc,
  input  wire logic         wbStb,
  input  wire logic         wbWe,
  input  wire logic [3:0]   wbSel,
  input  wire logic [31:0]  rdData,
  output logic      [31:0]  wbDatO,
  output logic              wbAck,
  output logic              wrStb,
  output logic              rdStb,
  output logic      [31:0]  wMask
);
  logic take;
  assign take = wbCyc & wbStb & ~wbAck;
  assign wrStb = take & wbWe;
  assign rdStb = take & ~wbWe;
  for (genvar b = 0; b < 4; b++)
  begin : g_mask
    assign wMask[b*8 +: 8] = {8{wbSel[b]}};
  end
  always_ff @(posedge clk)
  begin
    if (rst) wbAck <= 1'b0;
    else wbAck <= take;
  end
  always_ff @(posedge clk)
  begin
    if (rst) wbDatO <= RdZero;
    else if (rdStb) wbDatO <= rdData;
  end
  a_bus_ack_pulse: assert property (@(posedge clk) disable iff (rst)
    wbAck |=> !wbAck) else $error("ack held longer than one cycle");
  a_bus_ack_cause: assert property (@(posedge clk) disable iff (rst)
    take |=> wbAck) else $error("request not answered next cycle");
endmodule // isc_wb_slave
`default_nettype wire

//--- sim/isc_periph_model.sv
// Peripheral and core stand-in facing the interrupt source controller
`timescale 1ns/1ps
`default_nettype none
module isc_periph_model
  import isc_pkg::*;
(
  input  wire logic            clk,
  input  wire logic            rst,
  input  wire logic [SrcHi:2]  reqCmd,
  input  wire logic            wakeCmd,
  input  wire logic            wdogCmd,
  input  wire logic            irqReq,
  input  wire logic            fiqReq,
  output logic      [SrcHi:2]  periphReq,
  output logic                 wakeReq,
  output logic                 wdogReq,
  output logic      [7:0]      irqEntries,
  output logic      [7:0]      fiqEntries
);
  logic irqSeen_q;
  logic fiqSeen_q;
  //----------------------------------------
  // Peripheral request lines
  //----------------------------------------
  always_ff @(posedge clk)
  begin
    periphReq <= reqCmd;
    wakeReq   <= wakeCmd;
    wdogReq   <= wdogCmd;
  end
  //----------------------------------------
  // Core side: counts entries into IRQ and FIQ mode
  //----------------------------------------
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      irqSeen_q  <= 1'b0;
      irqEntries <= 8'h00;
      fiqSeen_q  <= 1'b0;
      fiqEntries <= 8'h00;
    end
    else
    begin
      irqSeen_q <= irqReq;
      fiqSeen_q <= fiqReq;
      if (irqReq && !irqSeen_q)
        irqEntries <= irqEntries + 8'h01;
      if (fiqReq && !fiqSeen_q)
        fiqEntries <= fiqEntries + 8'h01;
    end
  end
endmodule // isc_periph_model
`default_nettype wire

//--- sim/interrupt_source_controller_test.sv
// Self-checking bench for the interrupt source controller
`timescale 1ns/1ps
`default_nettype none
module interrupt_source_controller_test;
  import isc_pkg::*;
  logic            clk;
  logic            rst;
  logic [SrcHi:2]  reqCmd;
  logic            wakeCmd;
  logic            wdogCmd;
  logic [SrcHi:2]  periphReq;
  logic            wakeReq;
  logic            wdogReq;
  logic [7:0]      irqEntries;
  logic [7:0]      fiqEntries;
  logic            wbCyc;
  logic            wbStb;
  logic            wbWe;
  logic [AdrW-1:0] wbAdr;
  logic [3:0]      wbSel;
  logic [31:0]     wbDatI;
  logic [31:0]     wbDatO;
  logic            wbAck;
  logic            irqReq;
  logic            fiqReq;
  logic            intOut;
  int              errCount;
  int              testsRun;
  int              cycles;
  isc_periph_model model (.clk(clk), .rst(rst), .reqCmd(reqCmd),
    .wakeCmd(wakeCmd), .wdogCmd(wdogCmd), .irqReq(irqReq),
    .fiqReq(fiqReq), .periphReq(periphReq), .wakeReq(wakeReq),
    .wdogReq(wdogReq), .irqEntries(irqEntries), .fiqEntries(fiqEntries));
  isc_top uut (.clk(clk), .rst(rst), .periphReq(periphReq),
    .wakeReq(wakeReq), .wdogReq(wdogReq), .wbCyc(wbCyc), .wbStb(wbStb),
    .wbWe(wbWe), .wbAdr(wbAdr), .wbSel(wbSel), .wbDatI(wbDatI),
    .wbDatO(wbDatO), .wbAck(wbAck), .irqReq(irqReq), .fiqReq(fiqReq),
    .intOut(intOut));
  //----------------------------------------
  // Helpers
  //----------------------------------------
  task automatic tally_and_finish;
    if (errCount == 0 && testsRun > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] exp,
                     input logic [31:0] got);
    testsRun++;
    if (got !== exp)
    begin
      errCount++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic wb_cycle(input logic [AdrW-1:0] a, input logic w,
                          input logic [31:0] d, output logic [31:0] q);
    @(posedge clk);
    wbAdr  <= a;
    wbWe   <= w;
    wbDatI <= d;
    wbSel  <= 4'hF;
    wbCyc  <= 1'b1;
    wbStb  <= 1'b1;
    do
    begin
      @(posedge clk);
    end
    while (wbAck !== 1'b1);
    q = wbDatO;
    wbCyc <= 1'b0;
    wbStb <= 1'b0;
  endtask
  task automatic wr(input logic [AdrW-1:0] a, input logic [31:0] d);
    logic [31:0] q;
    wb_cycle(a, 1'b1, d, q);
  endtask
  task automatic rd_chk(input string nm, input logic [AdrW-1:0] a,
                        input logic [31:0] exp);
    logic [31:0] q;
    wb_cycle(a, 1'b0, 32'h0000_0000, q);
    chk(nm, exp, q);
  endtask
  task automatic drive(input logic [31:0] v, input logic wk, input logic wd);
    @(posedge clk);
    reqCmd  <= v[SrcHi:2];
    wakeCmd <= wk;
    wdogCmd <= wd;
  endtask
  task automatic settle;
    repeat (6) @(posedge clk);
    #1;
  endtask
  //----------------------------------------
  // Scenarios
  //----------------------------------------
  task automatic t_reset;
    rd_chk("irq_active_status", OffIrqSta, 32'h0000_0000);
    rd_chk("irqRaw", OffIrqRaw, 32'h0000_0000);
    rd_chk("irq_enable_mask", OffIrqEn, 32'h0000_0000);
    rd_chk("fiq_active_status", OffFiqSta, 32'h0000_0000);
    chk("irqReq", 32'h0, irqReq);
  endtask
  task automatic t_event;
    logic [7:0] e0;
    e0 = irqEntries;
    wr(OffEvtMsk, 32'h0000_0001);
    drive(32'h0000_0200, 1'b0, 1'b0);
    wr(OffIrqEn, 32'h0000_0200);
    settle();
    chk("irqReq", 32'h1, irqReq);
    chk("intOut", 32'h1, intOut);
    chk("entries", e0 + 8'h01, irqEntries);
    rd_chk("evtSta", OffEvtSta, 32'h0000_0001);
    wr(OffEvtSta, 32'h0000_0001);
    settle();
    chk("intOut", 32'h0, intOut);
    wr(OffIrqClr, 32'h0000_0200);
    drive(32'h0000_0000, 1'b0, 1'b0);
    settle();
    chk("irqReq", 32'h0, irqReq);
  endtask
  task automatic t_mask;
    drive(32'h0000_0700, 1'b0, 1'b0);
    wr(OffIrqEn, 32'h0000_0300);
    settle();
    rd_chk("irqRaw", OffIrqRaw, 32'h0000_0700);
    rd_chk("irq_active_status", OffIrqSta, 32'h0000_0300);
    wr(OffIrqClr, 32'h0000_0100);
    rd_chk("irq_enable_mask", OffIrqEn, 32'h0000_0200);
    rd_chk("irq_active_status", OffIrqSta, 32'h0000_0200);
    drive(32'h0000_0000, 1'b0, 1'b0);
    settle();
    rd_chk("irqRaw", OffIrqRaw, 32'h0000_0000);
    chk("irqReq", 32'h0, irqReq);
    wr(OffIrqClr, 32'hFFFF_FFFF);
  endtask
  task automatic t_swi;
    wr(OffSwi, 32'h0000_0001);
    wr(OffIrqEn, 32'h0000_0002);
    settle();
    rd_chk("irq_active_status", OffIrqSta, 32'h0000_0002);
    chk("irqReq", 32'h1, irqReq);
    wr(OffSwi, 32'h0000_0000);
    settle();
    chk("irqReq", 32'h0, irqReq);
    wr(OffIrqClr, 32'h0000_0002);
  endtask
  task automatic t_sources;
    drive(32'h0000_00C0, 1'b1, 1'b0);
    settle();
    rd_chk("irqRaw", OffIrqRaw, 32'h0000_00D0);
    drive(32'h0000_000C, 1'b0, 1'b1);
    settle();
    rd_chk("irqRaw", OffIrqRaw, 32'h0000_002C);
    drive(32'h0000_0000, 1'b0, 1'b0);
    settle();
    rd_chk("irqRaw", OffIrqRaw, 32'h0000_0000);
  endtask
  task automatic t_fiq;
    logic [7:0] e0;
    e0 = fiqEntries;
    drive(32'h0000_0400, 1'b0, 1'b0);
    wr(OffFiqEn, 32'h0000_0400);
    settle();
    rd_chk("fiq_active_status", OffFiqSta, 32'h0000_0401);
    rd_chk("irq_active_status", OffIrqSta, 32'h0000_0000);
    chk("fiqReq", 32'h1, fiqReq);
    chk("fiqEntries", e0 + 8'h01, fiqEntries);
    chk("irqReq", 32'h0, irqReq);
    wr(OffFiqClr, 32'h0000_0400);
    settle();
    chk("fiqReq", 32'h0, fiqReq);
    drive(32'h0000_0000, 1'b0, 1'b0);
  endtask
  task automatic t_misc;
    wr(OffPrio0 + 12'h004, 32'h0000_0030);
    rd_chk("prio1", OffPrio0 + 12'h004, 32'h0000_0030);
    wr(OffNest, 32'h0000_0001);
    rd_chk("nest", OffNest, 32'h0000_0001);
    wr(OffNest, 32'h0000_0000);
    wr(12'h200, 32'hFFFF_FFFF);
    rd_chk("unmapped", 12'h200, 32'h0000_0000);
  endtask
  task automatic t_nest;
    wr(OffPrio0 + 12'h004, 32'h0000_0013);
    drive(32'h0000_0100, 1'b0, 1'b0);
    wr(OffIrqEn, 32'h0000_0300);
    settle();
    rd_chk("vecOff", OffVec, 32'h0001_0768);
    rd_chk("svcOff", OffEoi, 32'h0000_0000);
    wr(OffNest, 32'h0000_0001);
    rd_chk("entrySta", OffIrqSta, 32'h0000_0100);
    rd_chk("vec1", OffVec, 32'h0001_0768);
    settle();
    chk("irqReq", 32'h0, irqReq);
    rd_chk("svc1", OffEoi, 32'h0000_0008);
    drive(32'h0000_0300, 1'b0, 1'b0);
    settle();
    chk("irqReq", 32'h1, irqReq);
    rd_chk("vec2", OffVec, 32'h0001_0B29);
    settle();
    chk("irqReq", 32'h0, irqReq);
    rd_chk("svc2", OffEoi, 32'h0000_000A);
    wr(OffEoi, 32'h0000_0000);
    rd_chk("svc3", OffEoi, 32'h0000_0008);
    wr(OffNest, 32'h0000_0000);
    rd_chk("svc4", OffEoi, 32'h0000_0000);
    wr(OffIrqClr, 32'hFFFF_FFFF);
    drive(32'h0000_0000, 1'b0, 1'b0);
    settle();
    chk("irqReq", 32'h0, irqReq);
  endtask
  task automatic t_rst_mid;
    wr(OffSwi, 32'h0000_0001);
    wr(OffIrqEn, 32'h0000_0002);
    settle();
    chk("irqReq", 32'h1, irqReq);
    @(posedge clk);
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    rd_chk("irq_enable_mask", OffIrqEn, 32'h0000_0000);
    rd_chk("swi", OffSwi, 32'h0000_0000);
    chk("irqReq", 32'h0, irqReq);
  endtask
  //----------------------------------------
  // Clock, reset, timeout and sequence
  //----------------------------------------
  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      errCount++;
      tally_and_finish();
    end
  end
  initial
  begin
    errCount = 0;
    testsRun = 0;
    cycles = 0;
    rst = 1'b1;
    reqCmd = '0;
    wakeCmd = 1'b0;
    wdogCmd = 1'b0;
    wbCyc = 1'b0;
    wbStb = 1'b0;
    wbWe = 1'b0;
    wbAdr = '0;
    wbSel = 4'h0;
    wbDatI = 32'h0000_0000;
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    t_reset();
    t_event();
    t_mask();
    t_swi();
    t_sources();
    t_fiq();
    t_misc();
    t_nest();
    t_rst_mid();
    tally_and_finish();
  end
endmodule // interrupt_source_controller_test
`default_nettype wire
